// ==== logic/tdb_pkg.sv ====
/*
  tdb_pkg: constants and carrier types of the timer DMA burst window.
  assumes a 16-bit register bank at 32-bit word offsets from control one.
*/
`default_nettype none
package tdb_pkg;
  // ----------------------------------------
  // register map
  // ----------------------------------------
  localparam logic [7:0]  TDB_CTRL1_OFS   = 8'h00;
  localparam logic [7:0]  TDB_DCTRL_OFS   = 8'h48;
  localparam logic [7:0]  TDB_WINDOW_OFS  = 8'h4C;
  localparam logic [7:0]  TDB_REG_STRIDE  = 8'h04;
  localparam logic [15:0] TDB_DCTRL_RST   = 16'h0000;
  localparam logic [15:0] TDB_WINDOW_RST  = 16'h0000;
  localparam logic [15:0] TDB_DCTRL_MASK  = 16'h1F1F;
  // ----------------------------------------
  // field layout
  // ----------------------------------------
  localparam int          TDB_BASE_LSB    = 0;
  localparam int          TDB_LEN_LSB     = 8;
  localparam int          TDB_FIELD_W     = 5;
  localparam logic [4:0]  TDB_LEN_MAX     = 5'h11;
  localparam logic [15:0] TDB_UNMAPPED    = 16'h0000;

  // one access of the bank as seen by the redirect
  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [15:0] wdata;
  } tdb_acc_t;

  // byte mode sequencer states
  typedef enum logic [1:0] {
    TDB_IDLE  = 2'b00,
    TDB_BURST = 2'b01,
    TDB_LOW   = 2'b11
  } tdb_state_t;
endpackage : tdb_pkg
`default_nettype wire

// ==== logic/tdb_index.sv ====
/*
  tdb_index: steps the burst transfer index once per window access.
  assumes one step pulse per access, same clock, synchronous reset.
*/
`timescale 1ns/1ps
`default_nettype none
module tdb_index
  import tdb_pkg::*;
#(
  parameter int W = 5
)
(
  input  wire logic         clock_i,
  input  wire logic         srst_i,
  input  wire logic         step_i,
  input  wire logic [W-1:0] last_i,
  output logic      [W-1:0] index_o,
  output logic              wrap_o
);
  // fewer than five bits cannot count the longest burst of eighteen
  if (W < 5)
  begin : g_width_check
    $error("index width too small");
  end

  logic [W-1:0] index_reg;
  logic [W-1:0] index_next;
  wire          at_last = (index_reg >= last_i);

  // wraps to zero after the final transfer so the next burst restarts
  assign index_next = at_last ? '0 : index_reg + {{(W-1){1'b0}}, 1'b1};
  assign wrap_o     = step_i & at_last;
  assign index_o    = index_reg;

  // index register
  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      index_reg <= '0;
    else if (step_i)
      index_reg <= index_next;
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  idx_bound_a: assert property (@(posedge clock_i) disable iff (srst_i)
    index_reg <= TDB_LEN_MAX) else $error("index beyond longest burst");
  idx_wrap_a: assert property (@(posedge clock_i) disable iff (srst_i)
    step_i && at_last |=> index_reg == '0) else $error("index did not wrap");
endmodule : tdb_index
`default_nettype wire

// ==== logic/tdb_window.sv ====
/*
  tdb_window: burst control register and data window of a timer bank.
  window accesses are redirected to consecutive timer registers; the
  timer bank sits behind the BANK_ port and answers reads combinationally.
  assumes plain register port master: one-cycle strobes, read data next cycle.
*/
// Summary of operation
// - base offset in bits 4:0, counted in registers from control one
// - length field bits 12:8, value plus one transfers, up to 18
// - window access goes to control one plus (base plus index) times four
// - transfer index steps per access, bounded by length, no software help
// - window accesses form one continuous walk over consecutive registers
// - 16-bit mode one datum per register; 8-bit mode high then low part
// - burst control at 0x48, reset zero, bits 7:5 and 15:13 reserved
// - data window at 0x4C, 16 bits, read and write, reset zero
`timescale 1ns/1ps
`default_nettype none
module tdb_window
  import tdb_pkg::*;
(
  input  wire logic        CLOCK_I,
  input  wire logic        SRST_I,
  input  wire logic [7:0]  ADDR_I,
  input  wire logic [15:0] WDATA_I,
  input  wire logic        WR_I,
  input  wire logic        RD_I,
  output logic      [15:0] RDATA_O,
  input  wire logic        BYTE_MODE_I,
  output logic             BANK_WR_O,
  output logic             BANK_RD_O,
  output logic      [7:0]  BANK_ADDR_O,
  output logic      [15:0] BANK_WDATA_O,
  input  wire logic [15:0] BANK_RDATA_I,
  output logic      [4:0]  INDEX_O,
  output logic             BURST_DONE_O
);
  // ----------------------------------------
  // registers
  // ----------------------------------------
  logic [15:0] dctrl_reg;
  logic [15:0] window_reg;
  logic [15:0] rdata_reg;
  logic [7:0]  hold_reg;
  logic        done_reg;
  tdb_state_t  state_reg;
  tdb_state_t  state_next;
  // access record driven onto the bank port
  tdb_acc_t    bank_acc;

  // ----------------------------------------
  // decode
  // ----------------------------------------
  wire         hit_dctrl  = (ADDR_I == TDB_DCTRL_OFS);
  wire         hit_window = (ADDR_I == TDB_WINDOW_OFS);
  wire         win_wr     = WR_I & hit_window;
  wire         win_rd     = RD_I & hit_window;
  wire  [4:0]  base_off   = dctrl_reg[TDB_BASE_LSB +: TDB_FIELD_W];
  wire  [4:0]  burst_len  = dctrl_reg[TDB_LEN_LSB +: TDB_FIELD_W];
  // lengths past eighteen transfers are reserved; they are clamped
  // so the index and the bank address stay in range
  wire  [4:0]  burst_last = (burst_len > TDB_LEN_MAX) ? TDB_LEN_MAX : burst_len;
  wire  [4:0]  index;
  wire         wrap;
  // byte mode: one datum spans two registers, second half steps on LOW
  wire         low_half   = (state_reg == TDB_LOW);
  wire         step       = win_wr | win_rd;
  wire  [5:0]  reg_num    = {1'b0, base_off} + {1'b0, index};
  wire  [7:0]  target     = TDB_CTRL1_OFS + 8'({reg_num, 2'b00});
  // bank data: high byte first in byte mode
  wire  [15:0] wr_payload = BYTE_MODE_I
                            ? (low_half ? {8'h00, hold_reg} : {8'h00, WDATA_I[15:8]})
                            : WDATA_I;
  wire  [15:0] rd_payload = BANK_RDATA_I;

  // index walker shared by all window accesses
  tdb_index #(.W(5)) u_index (
    .clock_i (CLOCK_I),
    .srst_i  (SRST_I),
    .step_i  (step),
    .last_i  (burst_last),
    .index_o (index),
    .wrap_o  (wrap)
  );

  // redirect window accesses onto the bank, carried as one access record
  assign bank_acc     = '{wr: win_wr, rd: win_rd, addr: target, wdata: wr_payload};
  assign BANK_WR_O    = bank_acc.wr;
  assign BANK_RD_O    = bank_acc.rd;
  assign BANK_ADDR_O  = bank_acc.addr;
  assign BANK_WDATA_O = bank_acc.wdata;
  assign INDEX_O      = index;
  assign BURST_DONE_O = done_reg;
  assign RDATA_O      = rdata_reg;

  // byte mode sequencer: high part then low part of one datum
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      TDB_IDLE:  state_next = step ? (BYTE_MODE_I ? TDB_LOW : TDB_BURST) : TDB_IDLE;
      TDB_BURST: state_next = wrap ? TDB_IDLE : (step & BYTE_MODE_I ? TDB_LOW : TDB_BURST);
      TDB_LOW:   state_next = step ? (wrap ? TDB_IDLE : TDB_BURST) : TDB_LOW;
      default:   state_next = TDB_IDLE;
    endcase
  end

  // control register: reserved bits stay zero
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
      dctrl_reg <= TDB_DCTRL_RST;
    else if (WR_I && hit_dctrl)
      dctrl_reg <= WDATA_I & TDB_DCTRL_MASK;
  end

  // window keeps the last datum that passed through it
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
      window_reg <= TDB_WINDOW_RST;
    else if (win_wr)
      window_reg <= WDATA_I;
    else if (win_rd)
      window_reg <= rd_payload;
  end

  // low byte kept for the second register of an 8-bit pair
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
      hold_reg <= 8'h00;
    else if (win_wr && !low_half)
      hold_reg <= WDATA_I[7:0];
  end

  // state and done flag
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
    begin
      state_reg <= TDB_IDLE;
      done_reg  <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      done_reg  <= wrap;
    end
  end

  // read data, one cycle after the strobe; unmapped reads zero
  always_ff @(posedge CLOCK_I)
  begin
    if (SRST_I)
      rdata_reg <= 16'h0000;
    else if (RD_I)
      rdata_reg <= hit_dctrl ? dctrl_reg : (hit_window ? rd_payload : TDB_UNMAPPED);
  end

  // ----------------------------------------
  // checks
  // ----------------------------------------
  // bank address follows base plus index, widened so the sum never wraps
  win_addr_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    step |-> BANK_ADDR_O == 8'({{1'b0, base_off} + {1'b0, index}, 2'b00}))
    else $error("bad redirect");
  rsv_zero_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (dctrl_reg & ~TDB_DCTRL_MASK) == 16'h0000) else $error("reserved bit set");
  rd_late_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    RD_I && hit_dctrl |=> RDATA_O == $past(dctrl_reg)) else $error("read data wrong");
  // inside a burst every window access moves the index one place on
  step_inc_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    step && index < burst_last |=> index == $past(index) + 5'd1) else $error("no step");
  ctl_write_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    WR_I && hit_dctrl |=> burst_len == $past(WDATA_I[12:8])) else $error("len lost");
  base_hold_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    WR_I && hit_dctrl |=> base_off == $past(WDATA_I[4:0])) else $error("base lost");
  win_store_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    win_wr |=> window_reg == $past(WDATA_I)) else $error("window not kept");
  byte_hi_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    win_wr && BYTE_MODE_I && !low_half |-> BANK_WDATA_O[7:0] == WDATA_I[15:8])
    else $error("high byte first");
  // the last transfer raises done once and sends the index home
  done_one_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    step && index == burst_last |=> BURST_DONE_O && index == 5'd0) else $error("no done");
  // the low half of an 8-bit pair carries the byte held from the first write
  byte_lo_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    win_wr && BYTE_MODE_I && low_half |-> BANK_WDATA_O == {8'h00, hold_reg})
    else $error("low byte lost");
  // 16-bit transfers pass the datum untouched
  word_pass_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    win_wr && !BYTE_MODE_I |-> BANK_WDATA_O == WDATA_I)
    else $error("word altered");
  // bank strobes only for window accesses, never for control or unmapped
  bank_strobe_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    (BANK_WR_O == (WR_I && ADDR_I == TDB_WINDOW_OFS))
    && (BANK_RD_O == (RD_I && ADDR_I == TDB_WINDOW_OFS)))
    else $error("stray bank strobe");
  // window reads return what the bank showed in the strobe cycle
  win_read_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    RD_I && hit_window |=> RDATA_O == $past(BANK_RDATA_I))
    else $error("window read wrong");
  // unmapped reads answer zero rather than stale data
  unmapped_rd_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    RD_I && !hit_dctrl && !hit_window |=> RDATA_O == 16'h0000)
    else $error("unmapped read not zero");
  // no window access, no index movement
  idx_hold_a: assert property (@(posedge CLOCK_I) disable iff (SRST_I)
    !step |=> index == $past(index))
    else $error("index moved");

  // ----------------------------------------
  // coverage
  // ----------------------------------------
  burst_end_c: cover property (@(posedge CLOCK_I) disable iff (SRST_I) BURST_DONE_O);
  byte_mode_c: cover property (@(posedge CLOCK_I) disable iff (SRST_I) low_half && step);
  long_burst_c: cover property (@(posedge CLOCK_I) disable iff (SRST_I)
    step && index == TDB_LEN_MAX);
  window_read_c: cover property (@(posedge CLOCK_I) disable iff (SRST_I) win_rd);
  ctl_write_c: cover property (@(posedge CLOCK_I) disable iff (SRST_I) WR_I && hit_dctrl);
endmodule : tdb_window
`default_nettype wire

// ==== bench/tdb_bank_model.sv ====
/*
  tdb_bank_model: timer register bank behind the burst window.
  assumes word offsets from control one and reads answered in the strobe cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module tdb_bank_model
(
  input  wire logic        clock_i,
  input  wire logic        wr_i,
  input  wire logic        rd_i,
  input  wire logic [7:0]  addr_i,
  input  wire logic [15:0] wdata_i,
  output logic      [15:0] rdata_o
);
  logic [15:0] regs [0:31];
  // ----------------------------------------
  // bank storage
  // ----------------------------------------
  // unselected read lines show the inverse, so stale data never passes
  assign rdata_o = rd_i ? regs[addr_i[6:2]] : ~regs[addr_i[6:2]];
  // one register per write strobe, cleared at start
  initial
  begin
    for (int i = 0; i < 32; i++)
      regs[i] = 16'h0000;
  end
  always @(posedge clock_i)
  begin
    if (wr_i)
      regs[addr_i[6:2]] <= wdata_i;
  end
endmodule : tdb_bank_model
`default_nettype wire

// ==== bench/timer_dma_burst_window_tb.sv ====
/*
  timer_dma_burst_window_tb: self-checking bench of the burst window.
  assumes the bank model answers reads in the strobe cycle.
*/
`timescale 1ns/1ps
`default_nettype none
module timer_dma_burst_window_tb;
  import tdb_pkg::*;
  logic        CLOCK_I = 0, SRST_I = 1, WR_I = 0, RD_I = 0, BYTE_MODE_I = 0;
  logic [7:0]  ADDR_I = 8'h00;
  logic [15:0] WDATA_I = 16'h0000;
  logic [15:0] RDATA_O, BANK_WDATA_O, BANK_RDATA_I;
  logic [7:0]  BANK_ADDR_O;
  logic [4:0]  INDEX_O;
  logic        BANK_WR_O, BANK_RD_O, BURST_DONE_O;
  int          errors = 0, compares = 0;
  logic [15:0] d;
  always #12.5 CLOCK_I = ~CLOCK_I;
  tdb_window tdb_window_i (.CLOCK_I(CLOCK_I), .SRST_I(SRST_I), .ADDR_I(ADDR_I),
    .WDATA_I(WDATA_I), .WR_I(WR_I), .RD_I(RD_I), .RDATA_O(RDATA_O),
    .BYTE_MODE_I(BYTE_MODE_I), .BANK_WR_O(BANK_WR_O), .BANK_RD_O(BANK_RD_O),
    .BANK_ADDR_O(BANK_ADDR_O), .BANK_WDATA_O(BANK_WDATA_O),
    .BANK_RDATA_I(BANK_RDATA_I), .INDEX_O(INDEX_O), .BURST_DONE_O(BURST_DONE_O));
  tdb_bank_model tdb_bank_model_i (.clock_i(CLOCK_I), .wr_i(BANK_WR_O), .rd_i(BANK_RD_O),
    .addr_i(BANK_ADDR_O), .wdata_i(BANK_WDATA_O), .rdata_o(BANK_RDATA_I));
  // ----------------------------------------
  // bus and compare helpers
  // ----------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp)
    begin
      errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge CLOCK_I);
    WR_I <= 1'b1; ADDR_I <= a; WDATA_I <= v;
    @(posedge CLOCK_I);
    WR_I <= 1'b0;
    #1;
  endtask : wr
  // read data appear in the cycle after the strobe and hold until the next read
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge CLOCK_I);
    RD_I <= 1'b1; ADDR_I <= a;
    @(posedge CLOCK_I);
    RD_I <= 1'b0;
    @(negedge CLOCK_I);
    v = RDATA_O;
  endtask : rd
  task automatic end_of_test;
    $display("compares=%0d errors=%0d", compares, errors);
    if (errors == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : end_of_test
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_regs;
    rd(TDB_DCTRL_OFS, d); chk(d, 16'h0000);
    rd(TDB_WINDOW_OFS, d); chk(d, 16'h0000);
    wr(TDB_DCTRL_OFS, 16'hFFFF);
    rd(TDB_DCTRL_OFS, d); chk(d, 16'h1F1F);
    rd(8'h50, d); chk(d, 16'h0000);
  endtask : t_regs
  // three transfers from base 2, index back to zero with done pulse
  task automatic t_short;
    wr(TDB_DCTRL_OFS, 16'h0202);
    for (int i = 0; i < 3; i++) wr(TDB_WINDOW_OFS, 16'hA000 + 16'(i));
    chk({10'h000, BURST_DONE_O, INDEX_O}, 16'h0020);
    for (int i = 0; i < 3; i++) chk(tdb_bank_model_i.regs[2 + i], 16'hA000 + 16'(i));
  endtask : t_short
  // longest burst of 18 written, then read back through the window
  task automatic t_long;
    wr(TDB_DCTRL_OFS, 16'h1101);
    for (int i = 0; i < 18; i++) wr(TDB_WINDOW_OFS, 16'h5A00 + 16'(i));
    chk(tdb_bank_model_i.regs[18], 16'h5A11);
    chk(tdb_bank_model_i.regs[19], 16'h0000);
    for (int i = 0; i < 18; i++)
    begin
      rd(TDB_WINDOW_OFS, d);
      chk(d, 16'h5A00 + 16'(i));
    end
  endtask : t_long
  // byte transfers: high part first, then low part to the next register
  task automatic t_byte;
    @(posedge CLOCK_I);
    BYTE_MODE_I <= 1'b1;
    wr(TDB_DCTRL_OFS, 16'h0105);
    wr(TDB_WINDOW_OFS, 16'hABCD);
    wr(TDB_WINDOW_OFS, 16'h0000);
    chk({8'h00, tdb_bank_model_i.regs[5][7:0]}, 16'h00AB);
    chk({8'h00, tdb_bank_model_i.regs[6][7:0]}, 16'h00CD);
    @(posedge CLOCK_I);
    BYTE_MODE_I <= 1'b0;
  endtask : t_byte
  initial
  begin
    #(25 * 3000);
    errors++;
    end_of_test();
  end
  initial
  begin
    repeat (4) @(posedge CLOCK_I);
    SRST_I <= 1'b0;
    t_regs();
    t_short();
    t_long();
    t_byte();
    end_of_test();
  end
endmodule : timer_dma_burst_window_tb
`default_nettype wire
